// *** hw/psag_top.v ***
// Program space address generator: picks the access kind for each request,
// registers the program address and strobes, and shapes read data back.
// Assumes the core presents requests for one cycle with stable operands and that
// the program memory returns a 24-bit word combinationally on mem_rdata.
`timescale 1ns/10ps
`default_nettype none
`include "psag_consts.vh"

module psag_top (
  // Clock, reset and the enable that freezes every register.
  input  wire                         clock,
  input  wire                         rst_b,
  input  wire                         clk_en,
  // Core requests and operands, all from logic on this clock.
  input  wire                         fetch_req,
  input  wire [`PSAG_PADDR_W-1:0]     program_counter,
  input  wire                         table_read_op,
  input  wire                         table_write_op,
  input  wire                         table_high_sel,
  input  wire                         table_byte_mode,
  input  wire                         data_req,
  input  wire                         data_we,
  input  wire [`PSAG_DATA_W-1:0]      effective_address,
  input  wire [`PSAG_DATA_W-1:0]      cpu_control_register,
  input  wire [`PSAG_PAGE_W-1:0]      table_page_select,
  input  wire [`PSAG_PAGE_W-1:0]      visibility_page_select,
  input  wire [`PSAG_DATA_W-1:0]      table_wdata,
  // Word returned by the program memory for the registered address.
  input  wire [`PSAG_WORD_W-1:0]      mem_rdata,
  // Registered strobes, addresses and read data toward the memories and the core.
  output reg  [`PSAG_PADDR_W-1:0]     pm_addr_ff,
  output reg                          pm_rd_ff,
  output reg                          pm_wr_ff,
  output reg                          pm_wr_high_ff,
  output reg  [`PSAG_DATA_W-1:0]      pm_wdata_ff,
  output reg                          pm_cfg_space_ff,
  output reg                          dm_sel_ff,
  output reg  [`PSAG_DATA_W-1:0]      dm_addr_ff,
  output reg                          dm_we_ff,
  output reg                          window_hit_ff,
  output reg                          window_wr_blocked_ff,
  output reg                          table_wr_blocked_ff,
  output reg  [`PSAG_DATA_W-1:0]      rdata_ff,
  output reg                          rdata_valid_ff
);

  wire                       table_active;
  wire                       win_enable;
  wire                       win_hit;
  wire                       cfg_page;
  reg  [2:0]                 kind;
  wire [`PSAG_PADDR_W-1:0]   paddr;
  reg                        pend_rd_ff;
  reg                        pend_high_ff;
  reg                        pend_byte_ff;
  reg                        pend_bsel_ff;
  // Next values of the request stage, one for each registered output.
  reg  [`PSAG_PADDR_W-1:0]   nxt_pm_addr;
  reg                        nxt_pm_rd;
  reg                        nxt_pm_wr;
  reg                        nxt_pm_wr_high;
  reg  [`PSAG_DATA_W-1:0]    nxt_pm_wdata;
  reg                        nxt_pm_cfg_space;
  reg                        nxt_dm_sel;
  reg  [`PSAG_DATA_W-1:0]    nxt_dm_addr;
  reg                        nxt_dm_we;
  reg                        nxt_window_hit;
  reg                        nxt_window_wr_blocked;
  reg                        nxt_table_wr_blocked;
  reg                        nxt_pend_rd;
  reg                        nxt_pend_high;
  reg                        nxt_pend_byte;
  reg                        nxt_pend_bsel;
  // Next values of the data stage.
  reg  [`PSAG_DATA_W-1:0]    nxt_rdata;
  reg                        nxt_rdata_valid;
  // Kind flags, each true for exactly one access kind.
  wire                       is_fetch;
  wire                       is_table;
  wire                       is_window;
  wire                       is_data;
  wire                       table_rd;
  wire                       table_wr;
  wire                       user_table_wr;

  // Table access holds off the window so the two never fight for the array. [R15]
  assign table_active = table_read_op | table_write_op;
  assign win_enable   = cpu_control_register[`PSAG_CTRL_WIN_BIT];
  // Both the top address bit and the control enable are needed for a remap. [R13]
  assign win_hit  = data_req & effective_address[`PSAG_EA_MSB] & win_enable & ~table_active;
  assign cfg_page = table_page_select[`PSAG_PAGE_W-1]; // [R03]

  // A one-hot view of the chosen kind keeps the strobe equations short.
  assign is_fetch      = (kind == `PSAG_KIND_FETCH);
  assign is_table      = (kind == `PSAG_KIND_TABLE);
  assign is_window     = (kind == `PSAG_KIND_WINDOW);
  assign is_data       = (kind == `PSAG_KIND_DATA);
  // Table qualifiers; a write aimed at configuration space never gets through.
  assign table_rd      = is_table & table_read_op; // [R10]
  assign table_wr      = is_table & table_write_op;
  assign user_table_wr = table_wr & ~cfg_page; // [R14]

  // Kind priority: table, then fetch, then window, then plain data.
  always @* begin
    if (table_active) begin
      kind = `PSAG_KIND_TABLE;
    end else if (fetch_req) begin
      kind = `PSAG_KIND_FETCH;
    end else if (win_hit) begin
      kind = `PSAG_KIND_WINDOW;
    end else if (data_req) begin
      kind = `PSAG_KIND_DATA; // [R17]
    end else begin
      kind = `PSAG_KIND_NONE;
    end
  end

  psag_addr_form u_form (
    .kind                   (kind),
    .table_page_select      (table_page_select),
    .visibility_page_select (visibility_page_select),
    .effective_address      (effective_address),
    .program_counter        (program_counter),
    .paddr                  (paddr)
  );

  // Selects the low or high byte of a 16-bit value into the low byte, upper byte zero.
  function [`PSAG_DATA_W-1:0] byte_pick;
    input [`PSAG_DATA_W-1:0] word;
    input                    upper;
    begin
      byte_pick = upper ? {8'h00, word[15:8]} : {8'h00, word[7:0]};
    end
  endfunction

  // High-half read: word mode puts the byte under a zero phantom byte, and byte
  // mode returns zero when the phantom byte is selected. Taking the mode flags as
  // arguments keeps the function free of hidden reads of module state.
  function [`PSAG_DATA_W-1:0] high_pick;
    input [7:0] hb;
    input       byte_mode;
    input       bsel;
    begin
      if (byte_mode && bsel) begin
        high_pick = `PSAG_RST_DATA; // [R16]
      end else begin
        high_pick = {8'h00, hb};
      end
    end
  endfunction

  // Request-stage next values, worked out from the chosen kind in every cycle.
  always @* begin
    nxt_pm_addr           = paddr;
    nxt_pm_cfg_space      = is_table & cfg_page; // [R03]
    nxt_pm_wdata          = table_wdata;
    // Reads into configuration space go ahead like any table read. [R10] [R12]
    // Fetches also read the array but return nothing through the data port.
    nxt_pm_rd             = is_fetch | table_rd | (is_window & ~data_we); // [R11]
    // Configuration space is read-only to table writes. [R14]
    nxt_pm_wr             = user_table_wr;
    nxt_pm_wr_high        = user_table_wr & table_high_sel; // [R12]
    nxt_table_wr_blocked  = table_wr & cfg_page; // [R14]
    nxt_window_hit        = is_window; // [R13]
    // The window never writes program memory; a write there is dropped. [R11]
    nxt_window_wr_blocked = is_window & data_we;
    nxt_dm_sel            = is_data; // [R17]
    nxt_dm_addr           = effective_address;
    nxt_dm_we             = is_data & data_we;
    // Only reads that hand data back to the core wait for the data stage.
    nxt_pend_rd           = table_rd | (is_window & ~data_we);
    nxt_pend_high         = is_table & table_high_sel;
    nxt_pend_byte         = is_table & table_byte_mode;
    nxt_pend_bsel         = effective_address[0]; // [R09]
  end

  // Program-memory side of the request stage. Holding everything while clk_en is
  // low keeps a stalled access exactly as the core presented it.
  always @(posedge clock) begin
    if (!rst_b) begin
      pm_addr_ff      <= `PSAG_RST_ADDR;
      pm_rd_ff        <= 1'b0;
      pm_wr_ff        <= 1'b0;
      pm_wr_high_ff   <= 1'b0;
      pm_wdata_ff     <= `PSAG_RST_DATA;
      pm_cfg_space_ff <= 1'b0;
    end else if (clk_en) begin
      pm_addr_ff      <= nxt_pm_addr;
      pm_rd_ff        <= nxt_pm_rd;
      pm_wr_ff        <= nxt_pm_wr;
      pm_wr_high_ff   <= nxt_pm_wr_high;
      pm_wdata_ff     <= nxt_pm_wdata;
      pm_cfg_space_ff <= nxt_pm_cfg_space;
    end
  end

  // Data-memory and status side of the request stage.
  always @(posedge clock) begin
    if (!rst_b) begin
      dm_sel_ff            <= 1'b0;
      dm_addr_ff           <= `PSAG_RST_DATA;
      dm_we_ff             <= 1'b0;
      window_hit_ff        <= 1'b0;
      window_wr_blocked_ff <= 1'b0;
      table_wr_blocked_ff  <= 1'b0;
    end else if (clk_en) begin
      dm_sel_ff            <= nxt_dm_sel;
      dm_addr_ff           <= nxt_dm_addr;
      dm_we_ff             <= nxt_dm_we;
      window_hit_ff        <= nxt_window_hit;
      window_wr_blocked_ff <= nxt_window_wr_blocked;
      table_wr_blocked_ff  <= nxt_table_wr_blocked;
    end
  end

  // Pending-read bookkeeping that tells the data stage how to shape the word.
  always @(posedge clock) begin
    if (!rst_b) begin
      pend_rd_ff   <= 1'b0;
      pend_high_ff <= 1'b0;
      pend_byte_ff <= 1'b0;
      pend_bsel_ff <= 1'b0;
    end else if (clk_en) begin
      pend_rd_ff   <= nxt_pend_rd;
      pend_high_ff <= nxt_pend_high;
      pend_byte_ff <= nxt_pend_byte;
      pend_bsel_ff <= nxt_pend_bsel;
    end
  end

  // Data-stage next values: the array word seen one enabled edge after its address.
  always @* begin
    nxt_rdata_valid = pend_rd_ff;
    nxt_rdata       = rdata_ff;
    if (pend_rd_ff) begin
      if (pend_high_ff) begin
        nxt_rdata = high_pick(mem_rdata[23:16], pend_byte_ff, pend_bsel_ff); // [R16] [R12]
      end else if (pend_byte_ff) begin
        nxt_rdata = byte_pick(mem_rdata[15:0], pend_bsel_ff); // [R12]
      end else begin
        nxt_rdata = mem_rdata[15:0]; // [R11]
      end
    end
  end

  // Data stage; read data holds until the next pending read replaces it.
  always @(posedge clock) begin
    if (!rst_b) begin
      rdata_ff       <= `PSAG_RST_DATA;
      rdata_valid_ff <= 1'b0;
    end else if (clk_en) begin
      rdata_ff       <= nxt_rdata;
      rdata_valid_ff <= nxt_rdata_valid;
    end
  end

endmodule // psag_top

`default_nettype wire

// *** hw/psag_consts.vh ***
// Constants for the program space address generator: widths, field positions,
// access-kind codes and reset values.
// Assumes inclusion by bare name from design files under hw/.
//
// Operation
// [R01] Program addresses are 24 bits wide and are built from 16-bit data-side operands.
// [R02] A table access places the 8-bit table page above the full 16-bit effective address.
// [R03] During a table access, address bit 23 picks user memory at 0 and configuration at 1.
// [R04] A visibility access joins the 8-bit visibility page with the low 15 address bits.
// [R05] A visibility access always clears program address bit 23 so it reaches user memory only.
// [R06] A visibility access takes address bit 15 from visibility page bit 0, not the address.
// [R07] An instruction fetch uses a clear bit 23, counter bits 22 to 1 and a clear bit 0.
// [R08] The lowest bit of a generated program word address is always zero.
// [R09] Table accesses are accepted at any byte address, aligned or not.
// [R10] Table reads into configuration memory are carried out.
// [R11] Visibility accesses are read-only and return only the low 16-bit word.
// [R12] Table accesses can reach every byte of a program word, including the upper byte.
// [R13] Data is redirected to program space only when address bit 15 and control bit 2 are set.
// [R14] No table write is performed when the page selects configuration memory.
// [R15] Visibility remapping is suspended while a table access is in progress.
// [R16] A high-half table read returns zero in bits 15 to 8, and the phantom byte reads zero.
// [R17] Without a table access or visibility hit, the data access goes to data memory untouched; the code drops it when fetch_req is also set.
`ifndef PSAG_CONSTS_VH
`define PSAG_CONSTS_VH

`define PSAG_PADDR_W       24
`define PSAG_DATA_W        16
`define PSAG_PAGE_W        8
`define PSAG_WORD_W        24
`define PSAG_CFG_BIT       23
`define PSAG_EA_MSB        15
`define PSAG_CTRL_WIN_BIT  2

`define PSAG_KIND_NONE     3'h0
`define PSAG_KIND_FETCH    3'h1
`define PSAG_KIND_TABLE    3'h2
`define PSAG_KIND_WINDOW   3'h3
`define PSAG_KIND_DATA     3'h4

`define PSAG_RST_ADDR      24'h000000
`define PSAG_RST_DATA      16'h0000

`endif

// *** hw/psag_addr_form.v ***
// Combinational address former: builds the program address for one access kind.
// Assumes the caller has already chosen the kind and qualifies the result.
`timescale 1ns/10ps
`default_nettype none
`include "psag_consts.vh"

module psag_addr_form (
  input  wire [2:0]                   kind,
  input  wire [`PSAG_PAGE_W-1:0]      table_page_select,
  input  wire [`PSAG_PAGE_W-1:0]      visibility_page_select,
  input  wire [`PSAG_DATA_W-1:0]      effective_address,
  input  wire [`PSAG_PADDR_W-1:0]     program_counter,
  output reg  [`PSAG_PADDR_W-1:0]     paddr
);

  // One address per kind; unused kinds park on zero so nothing random leaks out.
  always @* begin
    case (kind)
      `PSAG_KIND_FETCH: begin
        paddr = {1'b0, program_counter[22:1], 1'b0}; // [R07] [R08] [R01]
      end
      `PSAG_KIND_TABLE: begin
        // Page over the whole address; bit 0 kept as the byte select. [R02] [R03] [R09]
        paddr = {table_page_select, effective_address};
      end
      `PSAG_KIND_WINDOW: begin
        // Address bit 15 is dropped and page bit 0 lands on bit 15. [R04] [R05] [R06]
        // Bit 0 stays clear so the window reads whole aligned words. [R08]
        paddr = {1'b0, visibility_page_select, effective_address[14:1], 1'b0};
      end
      default: begin
        paddr = `PSAG_RST_ADDR;
      end
    endcase
  end

endmodule // psag_addr_form

`default_nettype wire

// *** tb/psag_pmem_model.sv ***
// Program memory model: a 24-bit word derived from the word address.
// Assumes the address is the generator's registered program address.
`timescale 1ns/10ps
`default_nettype none
module psag_pmem_model (
  input  wire logic [23:0] pm_addr_ff,
  output logic      [23:0] mem_rdata
);
  // The byte select is dropped, so an odd table address reads the whole word.
  assign mem_rdata = {pm_addr_ff[23:16] ^ pm_addr_ff[8:1] ^ 8'h3c, pm_addr_ff[16:1]};
endmodule // psag_pmem_model
`default_nettype wire

// *** tb/psag_top_sva.sv ***
// Checker for the program address generator, attached to its top module.
// Assumes one core clock and a synchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none
module psag_chk (
  input wire logic        clock, rst_b, clk_en, fetch_req, table_read_op, table_write_op,
  input wire logic        table_high_sel, data_req, data_we, pm_rd_ff, pm_wr_ff, pm_wr_high_ff,
  input wire logic        pm_cfg_space_ff, dm_sel_ff, window_hit_ff, window_wr_blocked_ff,
  input wire logic        table_wr_blocked_ff, rdata_valid_ff, dm_we_ff,
  input wire logic [7:0]  table_page_select, visibility_page_select,
  input wire logic [15:0] effective_address, cpu_control_register, table_wdata, pm_wdata_ff,
  input wire logic [15:0] dm_addr_ff,
  input wire logic [23:0] program_counter, pm_addr_ff
);
  // Request kinds in priority order: table, fetch, window, data.
  wire tbl = table_read_op | table_write_op;
  wire hit = effective_address[15] & cpu_control_register[2];
  wire win = clk_en & data_req & hit & !tbl & !fetch_req;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  // A table read taken, then one more enabled edge to return its data.
  sequence s_tbl_rd;
    clk_en && table_read_op ##1 clk_en;
  endsequence
  chk_table_addr:
    assert property (clk_en && tbl |=> pm_addr_ff == {$past(table_page_select),
      $past(effective_address)} && pm_cfg_space_ff == pm_addr_ff[23]) else $error("table addr");
  chk_window_addr:
    assert property (win && !data_we |=> pm_rd_ff && window_hit_ff && pm_addr_ff ==
      {1'b0, $past(visibility_page_select), $past(effective_address[14:1]), 1'b0})
      else $error("window addr");
  chk_window_ro:
    assert property (win && data_we |=> window_wr_blocked_ff && !pm_wr_ff && !pm_rd_ff &&
      !dm_we_ff) else $error("window wr");
  chk_fetch_addr:
    assert property (clk_en && fetch_req && !tbl |=> pm_rd_ff &&
      pm_addr_ff == {1'b0, $past(program_counter[22:1]), 1'b0}) else $error("fetch addr");
  chk_cfg_wr_block:
    assert property (clk_en && table_write_op && table_page_select[7] |=>
      table_wr_blocked_ff && !pm_wr_ff) else $error("config write");
  chk_user_write:
    assert property (clk_en && table_write_op && !table_page_select[7] |=> pm_wr_ff &&
      pm_wr_high_ff == $past(table_high_sel) && pm_wdata_ff == $past(table_wdata))
      else $error("table write");
  chk_window_off:
    assert property (clk_en && tbl |=> !window_hit_ff) else $error("window during table");
  chk_plain_data:
    assert property (clk_en && data_req && !tbl && !fetch_req && !hit |=> dm_sel_ff &&
      !window_hit_ff && dm_addr_ff == $past(effective_address) && dm_we_ff == $past(data_we))
      else $error("data access");
  chk_read_valid:
    assert property (s_tbl_rd |=> rdata_valid_ff) else $error("table read data");
endmodule // psag_chk
bind psag_top psag_chk u_chk (.*);
`default_nettype wire

// *** tb/psag_top_bench.sv ***
// Self-checking bench for the program address generator with a memory model.
// Assumes the checker is bound to the top module from its own file.
`timescale 1ns/10ps
`default_nettype none
module psag_top_bench;
  logic        clock = 0, rst_b = 0, clk_en = 0, fetch_req = 0, table_read_op = 0;
  logic        table_write_op = 0, table_high_sel = 0, table_byte_mode = 0, data_req = 0;
  logic        data_we = 0, prev_en = 0, pm_rd_ff, pm_wr_ff, pm_wr_high_ff, pm_cfg_space_ff;
  logic        dm_sel_ff, dm_we_ff, window_hit_ff, window_wr_blocked_ff, table_wr_blocked_ff;
  logic        rdata_valid_ff;
  logic [7:0]  table_page_select = 0, visibility_page_select = 0;
  logic [15:0] effective_address = 0, cpu_control_register = 0, table_wdata = 0;
  logic [15:0] pm_wdata_ff, dm_addr_ff, rdata_ff;
  logic [23:0] program_counter = 0, mem_rdata, pm_addr_ff;
  logic [31:0] seed = 32'h54d1;
  logic [15:0] expq[$];
  int          error_cnt = 0, checked = 0;
  psag_top uut (.*);
  psag_pmem_model pmem (.*);
  always #25 clock = ~clock;
  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task test_done;
    if (error_cnt == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  function logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  // Same scramble as the memory model, computed from the address we expect.
  function logic [23:0] mw(input logic [23:0] a);
    return {a[23:16] ^ a[8:1] ^ 8'h3c, a[16:1]};
  endfunction
  // Idle with the clock enabled first, so pending reads drain before reset.
  task reset_dut;
    {clk_en, fetch_req, table_read_op, table_write_op, data_req} <= 5'h10;
    if (rst_b) repeat (3) @(posedge clock);
    rst_b <= 1'b0;
    repeat (4) @(posedge clock);
    rst_b <= 1'b1;
  endtask
  // One random request; the expected word is queued when a read is taken.
  task drive(input logic [31:0] r, input logic [31:0] s);
    logic [2:0]  k;
    logic [23:0] w;
    logic [15:0] e;
    k = r[2:0];
    clk_en <= r[6:3] != 4'h0;
    fetch_req <= k == 3'h0;
    table_read_op <= k == 3'h1;
    table_write_op <= k == 3'h2;
    data_req <= k > 3'h2 || r[10];
    {table_high_sel, table_byte_mode, data_we} <= r[9:7];
    effective_address <= r[31:16];
    program_counter <= {s[7:0], r[31:16]};
    {cpu_control_register, visibility_page_select, table_page_select} <= s;
    table_wdata <= s[23:8];
    w = k == 3'h1 ? mw({s[7:0], r[31:16]}) : mw({1'b0, s[15:8], r[30:17], 1'b0});
    e = w[15:0];
    if (k == 3'h1 && r[9]) e = (r[8] && r[16]) ? 16'h0 : {8'h0, w[23:16]};
    else if (k == 3'h1 && r[8]) e = {8'h0, r[16] ? w[15:8] : w[7:0]};
    if (r[6:3] != 4'h0 && (k == 3'h1 || (k > 3'h2 && !r[7] && r[31] && s[18])))
      expq.push_back(e);
  endtask
  // A held strobe under a low enable is not fresh data, so only count enabled edges.
  always @(posedge clock) begin
    prev_en <= clk_en;
    if (rst_b && prev_en && rdata_valid_ff)
      check("rdata", rdata_ff, expq.size() != 0 ? expq.pop_front() : 16'hxxxx);
  end
  initial begin
    reset_dut;
    @(posedge clock);
    check("addr_after_reset", pm_addr_ff, 24'h0); // Reset value.
    for (int i = 0; i < 800; i++) begin
      @(posedge clock);
      seed = xs(seed);
      if (i == 400) reset_dut;
      else drive(seed, xs(seed));
    end
    @(posedge clock);
    reset_dut;
    check("reads_left", expq.size(), 24'h0);
    test_done;
  end
endmodule // psag_top_bench
`default_nettype wire
